// ### rtl/fifo_ctl_if.sv
`timescale 1ns/100ps
// ==========================================
// fifo configuration and flags between control and level tracker
interface fifo_ctl_if;
   logic [1:0] host_access_width;
   logic fifo_threshold_select;
   logic fifo_direction;
   logic fifo_soft_reset;
   logic full;
   logic empty;
   logic thr_pulse;
   modport ctl (output host_access_width, fifo_threshold_select, fifo_direction,
      fifo_soft_reset, input full, empty, thr_pulse);
   modport trk (input host_access_width, fifo_threshold_select, fifo_direction,
      fifo_soft_reset, output full, empty, thr_pulse);
endinterface

// ### rtl/fifo_level.sv
`timescale 1ns/100ps
// ==========================================
// fifo fill level, flags and threshold requests
module fifo_level (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic host_xfer,
   input wire logic card_byte,
   fifo_ctl_if.trk ctl
);
   logic [6:0] level_q;
   logic [6:0] moved_q;
   wire [6:0] width = {4'h0, 3'(sdr_pkg::ACC_MAX_BYTES - {1'b0, ctl.host_access_width})};
   wire [6:0] thr = ctl.fifo_threshold_select ? sdr_pkg::THR_HIGH_BYTES
      : sdr_pkg::THR_LOW_BYTES;
   // threshold counts bytes crossing the card side, so reads and writes pace alike
   wire [6:0] moved_sum = 7'(moved_q + 7'h01);
   wire hit = card_byte && (moved_sum >= thr);
   wire [6:0] host_add = ctl.fifo_direction ? width : 7'(-width);
   wire [6:0] card_add = ctl.fifo_direction ? 7'h7f : 7'h01;
   wire [6:0] step = 7'((host_xfer ? host_add : 7'h00) + (card_byte ? card_add : 7'h00));

   // flags follow the host access width
   assign ctl.full = level_q > 7'(sdr_pkg::FIFO_DEPTH_BYTES - width);
   assign ctl.empty = level_q < width;
   assign ctl.thr_pulse = hit && !ctl.fifo_soft_reset;

   // soft reset holds all state at zero while set
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         level_q <= 7'h00;
         moved_q <= 7'h00;
      end
      else if (ctl.fifo_soft_reset)
      begin
         level_q <= 7'h00;
         moved_q <= 7'h00;
      end
      else
      begin
         level_q <= 7'(level_q + step);
         if (card_byte) moved_q <= hit ? 7'(moved_sum - thr) : moved_sum;
      end
   end
endmodule

// ### rtl/resp_capture.sv
`timescale 1ns/100ps
// ==========================================
// response holding words and first byte
module resp_capture (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic resp_valid,
   input wire logic [1:0] fmt,
   input wire logic [135:0] resp_data,
   input wire logic sw_wr,
   input wire logic [1:0] sw_idx,
   input wire logic [31:0] sw_data,
   output logic [127:0] words,
   output logic [7:0] first_byte
);
   wire is_long = resp_valid && (fmt == sdr_pkg::FMT_R136);
   wire is_short = resp_valid && (fmt == sdr_pkg::FMT_R48 || fmt == sdr_pkg::FMT_R48_NOCRC);

   // one holding word per slice; new response always overwrites
   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_word
         logic [15:0] w_q;
         logic [15:0] short_val;
         if (i == 7) assign short_val = resp_data[39:24];
         else if (i == 6) assign short_val = resp_data[23:8];
         else assign short_val = {8'h00, resp_data[7:0]};
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n) w_q <= sdr_pkg::RST_WORD;
            else if (is_long) w_q <= resp_data[16*i +: 16];
            else if (is_short && i >= 5) w_q <= short_val;
            else if (sw_wr && sw_idx == 2'(i / 2)) w_q <= sw_data[16*(i%2) +: 16];
         end
         assign words[16*i +: 16] = w_q;
      end
   endgenerate

   // first byte: start, direction and index bits
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n) first_byte <= sdr_pkg::RST_BYTE;
      else if (is_long) first_byte <= resp_data[135:128];
      else if (is_short) first_byte <= resp_data[47:40];
   end
endmodule

// ### rtl/sdio_resp_ctrl.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - new response overwrites holding words always
// - eight sixteen-bit words, two per register
// - short response fills words seven to five
// - long response fills all eight words
// - first byte holds start, direction, index
// - write status token kept in byte
// - wait starts two card clocks after block
// - clearing request ends wait, releases line two
// - crc error before last block of multi read auto-requests wait
// - status shows wait, period, line one level
// - enables: read wait bit1, card bit0
// - wait start sets flag; write one clears
// - card interrupt sets flag; write one clears
// - access width code sets full/empty
// - threshold request every 32 or 64 bytes
// - direction bit: host reads or writes fifo
// - fifo soft reset holds state cleared
// - format code selects capture layout
module sdio_resp_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic resp_valid,
   input wire logic [1:0] response_format_code,
   input wire logic [135:0] resp_data,
   input wire logic wr_token_valid,
   input wire logic [7:0] wr_token,
   input wire logic rd_block_end,
   input wire logic rd_crc_error,
   input wire logic rd_multi_block,
   input wire logic rd_last_block,
   input wire logic card_irq_period,
   input wire logic card_clk,
   input wire logic card_data_line_one,
   input wire logic card_data_line_two_i,
   output logic card_data_line_two_o,
   output logic card_data_line_two_oe,
   input wire logic host_xfer,
   input wire logic card_byte,
   output logic fifo_full,
   output logic fifo_empty,
   output logic dma_req,
   output logic fifo_thr_irq,
   output logic card_event_irq
);
   // ==========================================
   // bus decode
   wire wr_en = psel && penable && pwrite;
   wire rd_setup = psel && !penable && !pwrite;
   wire hit_rsp = paddr[7:4] == 4'h0 && paddr[1:0] == 2'b00;
   wire hit_tok = paddr == sdr_pkg::OFF_TOKEN;
   wire hit_resp_command_index = paddr == sdr_pkg::OFF_RESP_COMMAND_INDEX;
   wire hit_rwc = paddr == sdr_pkg::OFF_RWCTL;
   wire hit_st = paddr == sdr_pkg::OFF_IOST;
   wire hit_ien = paddr == sdr_pkg::OFF_IEN;
   wire hit_ist = paddr == sdr_pkg::OFF_IST;
   wire hit_fc = paddr == sdr_pkg::OFF_FIFOCTL;
   wire mapped = hit_rsp || hit_tok || hit_resp_command_index || hit_rwc || hit_st || hit_ien
      || hit_ist || hit_fc;

   // zero-wait slave; unmapped access flags an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ==========================================
   // pin synchronisers
   logic [2:0] clk_s_q;
   logic [2:0] l1_s_q;
   logic [1:0] l2_s_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_s_q <= 3'h0;
         l1_s_q <= 3'h7;
         l2_s_q <= 2'h3;
      end
      else
      begin
         clk_s_q <= {clk_s_q[1:0], card_clk};
         l1_s_q <= {l1_s_q[1:0], card_data_line_one};
         l2_s_q <= {l2_s_q[0], card_data_line_two_i};
      end
   end
   // edges taken from stages two and three only
   wire card_rise = clk_s_q[1] && !clk_s_q[2];
   wire line_one_level = l1_s_q[1];
   wire line_one_fall = !l1_s_q[1] && l1_s_q[2];
   wire card_irq_seen = card_irq_period && line_one_fall;

   // ==========================================
   // response words and token
   logic [127:0] rsp_words;
   logic [7:0] first_byte;
   logic [7:0] token_q;
   resp_capture u_capture (
      .clk(pclk),
      .rst_n(presetn),
      .resp_valid(resp_valid),
      .fmt(response_format_code),
      .resp_data(resp_data),
      .sw_wr(wr_en && hit_rsp),
      .sw_idx(paddr[3:2]),
      .sw_data(pwdata),
      .words(rsp_words),
      .first_byte(first_byte)
   );

   // status token after each written block
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) token_q <= sdr_pkg::RST_BYTE;
      else if (wr_token_valid) token_q <= wr_token;
   end

   // ==========================================
   // read wait control
   logic req_q;
   logic auto_q;
   logic [1:0] ien_q;
   logic [1:0] ist_q;
   logic [1:0] edge_cnt_q;
   sdr_pkg::rw_state_t rw_q;
   sdr_pkg::rw_state_t rw_d;
   wire crc_auto = auto_q && rd_crc_error && rd_multi_block && !rd_last_block;
   wire req_clr = wr_en && hit_rwc && !pwdata[sdr_pkg::RWC_REQ];
   wire req_set = wr_en && hit_rwc && pwdata[sdr_pkg::RWC_REQ];
   wire wait_start = rw_q == sdr_pkg::RW_COUNT && card_rise
      && edge_cnt_q == 2'(sdr_pkg::RW_DELAY_EDGES - 2'h1);

   // auto set beats a same-cycle software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_q <= 1'b0;
         auto_q <= 1'b0;
      end
      else
      begin
         if (crc_auto) req_q <= 1'b1;
         else if (req_set) req_q <= 1'b1;
         else if (req_clr) req_q <= 1'b0;
         if (wr_en && hit_rwc) auto_q <= pwdata[sdr_pkg::RWC_AUTO];
      end
   end

   // arm on request, count card edges after block end, then hold
   always_comb
   begin
      rw_d = rw_q;
      case (rw_q)
         sdr_pkg::RW_IDLE: if (req_q) rw_d = sdr_pkg::RW_ARMED;
         sdr_pkg::RW_ARMED: if (rd_block_end) rw_d = sdr_pkg::RW_COUNT;
         sdr_pkg::RW_COUNT: if (wait_start) rw_d = sdr_pkg::RW_HOLD;
         default: rw_d = sdr_pkg::RW_HOLD;
      endcase
      if (!req_q) rw_d = sdr_pkg::RW_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) rw_q <= sdr_pkg::RW_IDLE;
      else rw_q <= rw_d;
   end

   // card clock edges since block end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) edge_cnt_q <= 2'h0;
      else if (rw_q != sdr_pkg::RW_COUNT) edge_cnt_q <= 2'h0;
      else if (card_rise) edge_cnt_q <= 2'(edge_cnt_q + 2'h1);
   end

   // line two driven low only while holding; released otherwise
   assign card_data_line_two_o = 1'b0;
   assign card_data_line_two_oe = rw_q == sdr_pkg::RW_HOLD;

   // ==========================================
   // card event flags, set beats clear
   wire [1:0] ev = {wait_start && ien_q[sdr_pkg::IRQ_RW],
      card_irq_seen && ien_q[sdr_pkg::IRQ_CARD]};
   wire [1:0] w1c = (wr_en && hit_ist) ? pwdata[1:0] : 2'b00;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ien_q <= 2'b00;
         ist_q <= 2'b00;
      end
      else
      begin
         if (wr_en && hit_ien) ien_q <= pwdata[1:0];
         ist_q <= ev | (ist_q & ~w1c);
      end
   end
   assign card_event_irq = |(ist_q & ien_q);

   // ==========================================
   // fifo control
   logic [4:0] fc_q;
   fifo_ctl_if fifo_bus ();
   assign fifo_bus.host_access_width = fc_q[sdr_pkg::FC_ACC +: 2];
   assign fifo_bus.fifo_threshold_select = fc_q[sdr_pkg::FC_LEV];
   assign fifo_bus.fifo_direction = fc_q[sdr_pkg::FC_DIR];
   assign fifo_bus.fifo_soft_reset = fc_q[sdr_pkg::FC_RST];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) fc_q <= 5'h00;
      else if (wr_en && hit_fc) fc_q <= pwdata[4:0];
   end

   fifo_level u_level (
      .clk(pclk),
      .rst_n(presetn),
      .host_xfer(host_xfer),
      .card_byte(card_byte),
      .ctl(fifo_bus)
   );
   assign fifo_full = fifo_bus.full;
   assign fifo_empty = fifo_bus.empty;
   assign dma_req = fifo_bus.thr_pulse;
   assign fifo_thr_irq = fifo_bus.thr_pulse;

   // ==========================================
   // read data, loaded in the setup cycle
   wire [31:0] rsp_sel = rsp_words[32*paddr[3:2] +: 32];
   wire [31:0] st_word = {29'h0, rw_q == sdr_pkg::RW_HOLD, card_irq_period,
      line_one_level};
   wire [31:0] rd_mux = hit_rsp ? rsp_sel
      : hit_tok ? {24'h0, token_q}
      : hit_resp_command_index ? {24'h0, first_byte}
      : hit_rwc ? {30'h0, auto_q, req_q}
      : hit_st ? st_word
      : hit_ien ? {30'h0, ien_q}
      : hit_ist ? {30'h0, ist_q}
      : hit_fc ? {27'h0, fc_q}
      : 32'h0000_0000;
   logic [31:0] prdata_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) prdata_q <= 32'h0000_0000;
      else if (rd_setup) prdata_q <= rd_mux;
   end
   assign prdata = prdata_q;

   // ==========================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // response capture and status token
   long_capture_a: assert property (
      resp_valid && response_format_code == sdr_pkg::FMT_R136
      |=> rsp_words[15:0] == $past(resp_data[15:0])
      && first_byte == $past(resp_data[135:128]))
      else $error("long response not captured");
   short_capture_a: assert property (
      resp_valid && response_format_code == sdr_pkg::FMT_R48
      |=> rsp_words[127:112] == $past(resp_data[39:24])
      && rsp_words[87:80] == $past(resp_data[7:0]))
      else $error("short response not captured");
   short_keep_a: assert property (
      resp_valid && response_format_code == sdr_pkg::FMT_R48 && !(wr_en && hit_rsp)
      |=> rsp_words[79:0] == $past(rsp_words[79:0]))
      else $error("short response touched low words");
   first_byte_a: assert property (
      resp_valid && response_format_code == sdr_pkg::FMT_R48_NOCRC
      |=> first_byte == $past(resp_data[47:40]))
      else $error("first byte wrong");
   token_store_a: assert property (
      wr_token_valid |=> token_q == $past(wr_token))
      else $error("status token not stored");

   // read wait
   wait_delay_a: assert property (
      rw_q == sdr_pkg::RW_ARMED && rd_block_end && req_q
      |=> !card_data_line_two_oe [*2])
      else $error("read wait started early");
   wait_start_a: assert property (
      wait_start && req_q |=> card_data_line_two_oe)
      else $error("read wait did not start");
   wait_hold_a: assert property (
      card_data_line_two_oe && req_q |=> card_data_line_two_oe)
      else $error("line two let go during read wait");
   line_echo_a: assert property (
      card_data_line_two_oe && $past(card_data_line_two_oe, 3) |-> !l2_s_q[1])
      else $error("line two not seen low");
   wait_release_a: assert property (
      !req_q |=> !card_data_line_two_oe)
      else $error("line two not released");
   auto_request_a: assert property (
      crc_auto |=> req_q && $stable(auto_q))
      else $error("auto read wait not requested");
   auto_keep_a: assert property (
      !(wr_en && hit_rwc) |=> $stable(auto_q))
      else $error("auto enable changed by hardware");
   status_wait_a: assert property (
      rd_setup && hit_st |=> prdata[sdr_pkg::ST_RDWAIT] == $past(card_data_line_two_oe))
      else $error("wait status bit wrong");

   // card event flags
   enable_write_a: assert property (
      wr_en && hit_ien |=> ien_q == $past(pwdata[1:0]))
      else $error("enable bits not written");
   rws_flag_a: assert property (
      wait_start && ien_q[1]
      |=> ist_q[1] ##1 ist_q[1] || $past(w1c[1]))
      else $error("read wait flag lost");
   card_flag_a: assert property (
      card_irq_seen && ien_q[0] |=> ist_q[0])
      else $error("card flag not set");
   card_mask_a: assert property (
      card_irq_seen && !ien_q[0] && !ist_q[0] |=> !ist_q[0])
      else $error("masked card interrupt flagged");
   w1c_clear_a: assert property (
      wr_en && hit_ist && pwdata[0] && !ev[0] |=> !ist_q[0])
      else $error("card flag not cleared");
   event_out_a: assert property (
      card_event_irq |-> (ist_q[1] && ien_q[1]) || (ist_q[0] && ien_q[0]))
      else $error("event output without flag");
   event_on_a: assert property (
      (ist_q[1] && ien_q[1]) || (ist_q[0] && ien_q[0]) |-> card_event_irq)
      else $error("event output missing");

   // fifo flags and threshold
   full_empty_a: assert property (
      fifo_full |-> !fifo_empty)
      else $error("fifo full and empty at once");
   soft_reset_a: assert property (
      fc_q[sdr_pkg::FC_RST] |=> fifo_empty && !fifo_full)
      else $error("fifo not cleared by soft reset");
   thr_single_a: assert property (
      dma_req |=> !dma_req)
      else $error("threshold request repeated");
endmodule

// ### rtl/sdr_pkg.sv
package sdr_pkg;
   // ==========================================
   // register byte offsets
   localparam logic [7:0] OFF_RSP01 = 8'h00;
   localparam logic [7:0] OFF_RSP23 = 8'h04;
   localparam logic [7:0] OFF_RSP45 = 8'h08;
   localparam logic [7:0] OFF_RSP67 = 8'h0c;
   localparam logic [7:0] OFF_TOKEN = 8'h10;
   localparam logic [7:0] OFF_RESP_COMMAND_INDEX = 8'h14;
   localparam logic [7:0] OFF_RWCTL = 8'h18;
   localparam logic [7:0] OFF_IOST = 8'h1c;
   localparam logic [7:0] OFF_IEN = 8'h20;
   localparam logic [7:0] OFF_IST = 8'h24;
   localparam logic [7:0] OFF_FIFOCTL = 8'h28;
   // ==========================================
   // field positions
   localparam int RWC_REQ = 0;
   localparam int RWC_AUTO = 1;
   localparam int ST_LINE1 = 0;
   localparam int ST_PERIOD = 1;
   localparam int ST_RDWAIT = 2;
   localparam int IRQ_CARD = 0;
   localparam int IRQ_RW = 1;
   localparam int FC_RST = 0;
   localparam int FC_DIR = 1;
   localparam int FC_LEV = 2;
   localparam int FC_ACC = 3;
   // ==========================================
   // reset values, codes and counts
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] FMT_NONE = 2'h0;
   localparam logic [1:0] FMT_R48 = 2'h1;
   localparam logic [1:0] FMT_R136 = 2'h2;
   localparam logic [1:0] FMT_R48_NOCRC = 2'h3;
   localparam logic [1:0] RW_DELAY_EDGES = 2'h2;
   localparam logic [6:0] THR_LOW_BYTES = 7'h20;
   localparam logic [6:0] THR_HIGH_BYTES = 7'h40;
   localparam logic [6:0] FIFO_DEPTH_BYTES = 7'h40;
   localparam logic [2:0] ACC_MAX_BYTES = 3'h4;
   typedef enum logic [1:0] {
      RW_IDLE = 2'b00,
      RW_ARMED = 2'b01,
      RW_COUNT = 2'b10,
      RW_HOLD = 2'b11
   } rw_state_t;
endpackage

// ### test/card_model.sv
`timescale 1ns/100ps
// ==========================================
// card side: link clock, line one, line two with pull-up
module card_model (
   output logic card_clk,
   output logic line_one,
   input wire logic dat2_o,
   input wire logic dat2_oe,
   output logic dat2
);
   // clock stands still between bursts, so only the edges we send are counted
   initial
   begin
      card_clk = 1'b0;
      line_one = 1'b1;
   end
   // pull-up wins once the host lets go of line two
   assign dat2 = dat2_oe ? dat2_o : 1'b1;
   // n link clock periods at 320 ns
   task automatic clocks(input int n);
      repeat (n)
      begin
         #160 card_clk = 1'b1;
         #160 card_clk = 1'b0;
      end
   endtask
   // card signals an interrupt by pulling line one low
   task automatic set_line_one(input logic v);
      #37 line_one = v;
   endtask
endmodule

// ### test/tb.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); end end
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] pulses;
   logic [1:0] fmt;
   logic [135:0] resp_data;
   logic [7:0] tok;
   logic multi, last, period, card_clk, line_one, dat2, dat2_o, dat2_oe;
   logic fifo_full, fifo_empty, dma_req, thr_irq, event_irq;
   int errors, checks, cycles, dma_cnt;
   localparam logic [135:0] L = 136'h3f_0011_2233_4455_6677_8899_aabb_ccdd_eeff;
   // ==========================================
   // clock, timeout and threshold pulse monitor
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         errors++;
         give_verdict();
      end
   end
   // sampled mid-cycle so the one-cycle pulse is never missed
   always @(negedge pclk)
   begin
      if (dma_req === 1'b1)
      begin
         dma_cnt++;
         `CHK(thr_irq, 1'b1)
      end
   end
   sdio_resp_ctrl u_sdio_resp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .resp_valid(pulses[4]),
      .response_format_code(fmt), .resp_data(resp_data), .wr_token_valid(pulses[5]),
      .wr_token(tok), .rd_block_end(pulses[0]), .rd_crc_error(pulses[1]),
      .rd_multi_block(multi), .rd_last_block(last), .card_irq_period(period),
      .card_clk(card_clk), .card_data_line_one(line_one), .card_data_line_two_i(dat2),
      .card_data_line_two_o(dat2_o), .card_data_line_two_oe(dat2_oe),
      .host_xfer(pulses[2]), .card_byte(pulses[3]), .fifo_full(fifo_full),
      .fifo_empty(fifo_empty), .dma_req(dma_req), .fifo_thr_irq(thr_irq),
      .card_event_irq(event_irq));
   card_model u_card_model (.card_clk(card_clk), .line_one(line_one), .dat2_o(dat2_o),
      .dat2_oe(dat2_oe), .dat2(dat2));
   // ==========================================
   // bus and stimulus tasks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // idle cycles, ending mid-cycle where outputs are settled
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic pulse(input logic [5:0] m, input int n);
      repeat (n)
      begin
         @(posedge pclk);
         pulses <= m;
         @(posedge pclk);
         pulses <= 6'h00;
      end
   endtask
   task automatic resp(input logic [1:0] f, input logic [135:0] d);
      @(posedge pclk);
      fmt <= f;
      resp_data <= d;
      pulse(6'h10, 1);
   endtask
   task give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, pulses, fmt, resp_data, tok} = '0;
      {multi, last, period, presetn, errors, checks, cycles, dma_cnt} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      idle(1);
      `CHK(fifo_empty, 1'b1)
      chk(sdr_pkg::OFF_IST, 32'h0);
      // long response, then short ones over it
      resp(sdr_pkg::FMT_R136, L);
      for (int i = 0; i < 4; i++)
         chk(sdr_pkg::OFF_RSP01 + 8'(4 * i), L[32 * i +: 32]);
      chk(sdr_pkg::OFF_RESP_COMMAND_INDEX, 32'h3f);
      resp(sdr_pkg::FMT_R48, {88'h0, 48'h95_1234_5678_9a});
      chk(sdr_pkg::OFF_RSP67, 32'h1234_5678);
      chk(sdr_pkg::OFF_RSP45, 32'h009a_6677);
      chk(sdr_pkg::OFF_RSP23, L[63:32]);
      chk(sdr_pkg::OFF_RESP_COMMAND_INDEX, 32'h95);
      resp(sdr_pkg::FMT_R48_NOCRC, {88'h0, 48'h41_cafe_beef_01});
      resp(sdr_pkg::FMT_NONE, '1);
      chk(sdr_pkg::OFF_RSP67, 32'hcafe_beef);
      chk(sdr_pkg::OFF_RSP45, 32'h0001_6677);
      tok <= 8'ha5;
      pulse(6'h20, 1);
      wr(sdr_pkg::OFF_TOKEN, 32'hff);
      chk(sdr_pkg::OFF_TOKEN, 32'ha5);
      // read wait counted in link clock edges
      wr(sdr_pkg::OFF_IEN, 32'h3);
      chk(sdr_pkg::OFF_IEN, 32'h3);
      wr(sdr_pkg::OFF_RWCTL, 32'h1);
      idle(2);
      pulse(6'h01, 1);
      idle(1);
      u_card_model.clocks(1);
      idle(6);
      `CHK(dat2_oe, 1'b0)
      u_card_model.clocks(1);
      idle(6);
      `CHK(dat2, 1'b0)
      chk(sdr_pkg::OFF_IOST, 32'h5);
      chk(sdr_pkg::OFF_IST, 32'h2);
      idle(0);
      `CHK(event_irq, 1'b1)
      wr(sdr_pkg::OFF_IST, 32'h0);
      chk(sdr_pkg::OFF_IST, 32'h2);
      wr(sdr_pkg::OFF_IST, 32'h2);
      idle(1);
      `CHK(event_irq, 1'b0)
      wr(sdr_pkg::OFF_RWCTL, 32'h0);
      idle(2);
      `CHK(dat2, 1'b1)
      chk(sdr_pkg::OFF_IOST, 32'h1);
      // automatic request on crc error, not on the last block
      wr(sdr_pkg::OFF_RWCTL, 32'h2);
      multi <= 1'b1;
      last <= 1'b1;
      pulse(6'h02, 1);
      idle(2);
      chk(sdr_pkg::OFF_RWCTL, 32'h2);
      last <= 1'b0;
      pulse(6'h02, 1);
      idle(2);
      chk(sdr_pkg::OFF_RWCTL, 32'h3);
      wr(sdr_pkg::OFF_RWCTL, 32'h2);
      chk(sdr_pkg::OFF_RWCTL, 32'h2);
      // card interrupt, masked then enabled
      wr(sdr_pkg::OFF_IEN, 32'h2);
      period <= 1'b1;
      u_card_model.set_line_one(1'b0);
      idle(4);
      chk(sdr_pkg::OFF_IOST, 32'h2);
      chk(sdr_pkg::OFF_IST, 32'h0);
      u_card_model.set_line_one(1'b1);
      wr(sdr_pkg::OFF_IEN, 32'h1);
      u_card_model.set_line_one(1'b0);
      idle(4);
      chk(sdr_pkg::OFF_IST, 32'h1);
      idle(0);
      `CHK(event_irq, 1'b1)
      wr(sdr_pkg::OFF_IST, 32'h1);
      chk(sdr_pkg::OFF_IST, 32'h0);
      // fifo: one, four and three byte widths; card fills, then host writes
      wr(sdr_pkg::OFF_FIFOCTL, 32'h18);
      pulse(6'h08, 31);
      idle(2);
      `CHK(dma_cnt, 0)
      `CHK(fifo_empty, 1'b0)
      pulse(6'h08, 1);
      idle(2);
      `CHK(dma_cnt, 1)
      wr(sdr_pkg::OFF_FIFOCTL, 32'h19);
      idle(1);
      `CHK(fifo_empty, 1'b1)
      wr(sdr_pkg::OFF_FIFOCTL, 32'h1c);
      pulse(6'h08, 63);
      idle(2);
      `CHK(fifo_full, 1'b0)
      `CHK(dma_cnt, 1)
      pulse(6'h08, 1);
      idle(2);
      `CHK(fifo_full, 1'b1)
      `CHK(dma_cnt, 2)
      wr(sdr_pkg::OFF_FIFOCTL, 32'h05);
      wr(sdr_pkg::OFF_FIFOCTL, 32'h04);
      pulse(6'h08, 3);
      idle(2);
      `CHK(fifo_empty, 1'b1)
      wr(sdr_pkg::OFF_FIFOCTL, 32'h0c);
      idle(1);
      `CHK(fifo_empty, 1'b0)
      wr(sdr_pkg::OFF_FIFOCTL, 32'h1b);
      wr(sdr_pkg::OFF_FIFOCTL, 32'h1a);
      pulse(6'h04, 1);
      idle(2);
      `CHK(fifo_empty, 1'b0)
      // unmapped place is refused
      apb(1'b0, 8'h30, 32'h0);
      `CHK(err, 1'b1)
      give_verdict();
   end
endmodule
